// *** rtl/lbs_lin_break_sync.sv ***
`timescale 1ns/10ps
// Functional notes
// R1: Bits 7..4 choose the stop edge count; a control bit picks falling or rising.
// R2: Stop edge count resets to three.
// R3: Bits 3..0 give the falling edge count that starts the sync timer.
// R4: Start edge count resets to two.
// R5: The falling edge opening the break is edge number one.
// R6: Software writes zero to edge setup bits 31..8.
// R7: Sync timer is 16 bits, ticks at 5 MHz, and is readable.
// R8: Break timer is 12 bits, ticks at 131 kHz; a read returns it.
// R9: Any bus falling edge or a read of the break timer clears it.
// R10: A write to the break location loads the compare value only.
// R11: In LIN mode a timer match with compare raises the interrupt and status bit 0.
// R12: After the match the break timer runs until the rising edge.
// R13: Break timer overflow without a rising edge raises interrupt and status bit 4.
// R14: Compare resets to 0x47 and software may rewrite it.
// R15: Sync timing happens only after a valid break match.
// R16: The master holds the bus low at least 13 bits for a break.
// R17: A break is found at any time; a bus held low is a fault.
// R18: Baud rate is the first-to-fifth sync falling edge interval over eight.
// R19: The identifier byte carries six identifier bits plus parity.
// R20: A frame carries one to eight data bytes chosen by the master.
// R21: Sync logic works only while enable bit 2 is set.
// R22: The reset control bit restores defaults and self-clears after 15 us.
// R23: A mode bit selects LIN when clear and pulse mode when set.
// R24: The sync timer holds its final count until the next break.
module lbs_lin_break_sync import lbs_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic lin_rx,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic lin_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] inc4(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return (a == ADDR_STATUS) || (a == ADDR_CONTROL) || (a == ADDR_SYNC_TIMER) ||
           (a == ADDR_EDGE_SETUP) || (a == ADDR_BRK);
  endfunction

  lbs_state_type q;
  lbs_state_type next_q;
  logic fall;
  logic rise;
  logic sync_tick;
  logic lp_tick;
  logic run_ok;
  logic rd_brk;
  logic wr_fire;
  logic match_cause;

  assign fall = q.rx_prev & ~q.rx_sync;
  assign rise = ~q.rx_prev & q.rx_sync;
  assign sync_tick = q.sync_div == 2'(SYNC_DIV - 1);
  assign lp_tick = q.lp_div == 8'(LP_DIV - 1);
  assign run_ok = q.control[CTL_ENABLE] & ~q.control[CTL_RESET]; // see R21
  assign rd_brk = s_axi_arvalid & s_axi_arready & (s_axi_araddr == ADDR_BRK);
  assign wr_fire = q.axi.aw_ok & q.axi.w_ok & ~q.axi.b_valid;
  assign match_cause = run_ok & ~q.control[CTL_MODE] & q.brk_run & lp_tick & ~fall &
                       ~rd_brk & (q.brk_cnt != 12'hfff) & (12'(q.brk_cnt + 12'h1) == q.cmp);

  assign s_axi_awready = ~q.axi.aw_ok & ~q.axi.b_valid;
  assign s_axi_wready = ~q.axi.w_ok & ~q.axi.b_valid;
  assign s_axi_arready = ~q.axi.r_valid;
  assign s_axi_bvalid = q.axi.b_valid;
  assign s_axi_bresp = q.axi.b_resp;
  assign s_axi_rvalid = q.axi.r_valid;
  assign s_axi_rdata = q.axi.r_data;
  assign s_axi_rresp = q.axi.r_resp;
  assign lin_irq = q.irq;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [3:0] nf;
    logic [3:0] ns;
    logic stop_ev;
    wv = 32'h0;
    nf = inc4(q.fall_cnt);
    ns = inc4(q.stop_cnt);
    stop_ev = 1'b0;
    next_q = q;
    next_q.irq = 1'b0;
    next_q.rx_meta = lin_rx;
    next_q.rx_sync = q.rx_meta;
    next_q.rx_prev = q.rx_sync;
    next_q.sync_div = sync_tick ? 2'h0 : q.sync_div + 2'h1;
    next_q.lp_div = lp_tick ? 8'h0 : q.lp_div + 8'h1;

    // Bus slave: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.axi.aw_ok = 1'b1;
      next_q.axi.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.axi.w_ok = 1'b1;
      next_q.axi.w_data = s_axi_wdata;
      next_q.axi.w_strb = s_axi_wstrb;
    end
    if (q.axi.b_valid && s_axi_bready) begin
      next_q.axi.b_valid = 1'b0;
    end
    if (wr_fire) begin
      next_q.axi.aw_ok = 1'b0;
      next_q.axi.w_ok = 1'b0;
      next_q.axi.b_valid = 1'b1;
      next_q.axi.b_resp = mapped(q.axi.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (q.axi.aw_addr)
        ADDR_STATUS: begin
          wv = wmask(32'h0, q.axi.w_data, q.axi.w_strb);
          next_q.status = q.status & ~wv[5:0];
        end
        ADDR_CONTROL: begin
          wv = wmask({23'h0, q.control}, q.axi.w_data, q.axi.w_strb);
          next_q.control = wv[8:0];
        end
        ADDR_SYNC_TIMER: begin
          wv = wmask({16'h0, q.sync_cnt}, q.axi.w_data, q.axi.w_strb);
          next_q.sync_cnt = wv[15:0];
        end
        ADDR_EDGE_SETUP: begin
          // Upper bits are expected as zero and are not stored. see R6
          wv = wmask({24'h0, q.edge_setup}, q.axi.w_data, q.axi.w_strb);
          next_q.edge_setup = wv[7:0];
        end
        ADDR_BRK: begin
          wv = wmask({20'h0, q.cmp}, q.axi.w_data, q.axi.w_strb); // see R10
          next_q.cmp = wv[11:0]; // see R14
        end
        default: begin
          next_q.axi.b_resp = RESP_SLVERR;
        end
      endcase
    end
    if (q.axi.r_valid && s_axi_rready) begin
      next_q.axi.r_valid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.axi.r_valid = 1'b1;
      next_q.axi.r_resp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_STATUS: next_q.axi.r_data = {26'h0, q.status};
        ADDR_CONTROL: next_q.axi.r_data = {23'h0, q.control};
        ADDR_SYNC_TIMER: next_q.axi.r_data = {16'h0, q.sync_cnt}; // see R7
        ADDR_EDGE_SETUP: next_q.axi.r_data = {24'h0, q.edge_setup};
        ADDR_BRK: next_q.axi.r_data = {20'h0, q.brk_cnt}; // see R8
        default: begin
          next_q.axi.r_data = 32'h0;
          next_q.axi.r_resp = RESP_SLVERR;
        end
      endcase
    end

    // Self-clearing control bits share one 15 us counter.
    if (q.control[CTL_RESET] || q.control[CTL_EDGE_CLR]) begin
      if (q.clr_cnt == 9'(SELF_CLR_CYC - 1)) begin
        next_q.clr_cnt = 9'h0;
        next_q.control[CTL_RESET] = 1'b0; // see R22
        next_q.control[CTL_EDGE_CLR] = 1'b0;
      end else begin
        next_q.clr_cnt = q.clr_cnt + 9'h1;
      end
    end else begin
      next_q.clr_cnt = 9'h0;
    end

    if (q.control[CTL_RESET]) begin
      // Hold every part of the sync logic at its default. see R22
      next_q.edge_setup = EDGE_SETUP_RESET;
      next_q.cmp = BRK_CMP_RESET;
      next_q.brk_cnt = 12'h0;
      next_q.brk_run = 1'b0;
      next_q.brk_ok = 1'b0;
      next_q.sync_st = LBS_IDLE;
      next_q.sync_cnt = 16'h0;
      next_q.fall_cnt = 4'h0;
      next_q.stop_cnt = 4'h0;
      next_q.status = 6'h0;
    end else if (!q.control[CTL_ENABLE]) begin
      next_q.brk_run = 1'b0; // see R21
      next_q.brk_ok = 1'b0;
    end else begin
      // Break timer: any fall restarts it, so a break is seen at any time. see R17
      if (fall) begin
        next_q.brk_cnt = 12'h0; // see R9
        next_q.brk_run = 1'b1;
      end else if (rd_brk) begin
        next_q.brk_cnt = 12'h0; // see R9
      end else if (q.brk_run && lp_tick) begin
        if (q.brk_cnt == 12'hfff) begin
          next_q.brk_cnt = 12'h0;
          next_q.brk_run = 1'b0;
          next_q.brk_ok = 1'b0;
          next_q.sync_st = LBS_IDLE;
          next_q.status[ST_BRK_ERR] = 1'b1; // see R13
          next_q.irq = 1'b1;
        end else begin
          next_q.brk_cnt = q.brk_cnt + 12'h1; // see R12
        end
      end
      if (rise) begin
        next_q.brk_run = 1'b0; // see R12
      end

      if (match_cause) begin
        // The fall that began this low is edge one. see R5
        next_q.status[ST_BREAK] = 1'b1; // see R11
        next_q.irq = 1'b1;
        next_q.brk_ok = 1'b1;
        next_q.fall_cnt = 4'h1;
        next_q.stop_cnt = q.control[CTL_STOP_RISE] ? 4'h0 : 4'h1;
        next_q.sync_cnt = 16'h0;
        next_q.sync_st = (q.edge_setup[START_EDGE_LSB +: 4] <= 4'h1) ? LBS_RUN : LBS_ARMED;
      end else if (q.brk_ok && !q.control[CTL_MODE]) begin
        // Sync timing only follows a valid break. see R15
        if (fall) begin
          next_q.fall_cnt = nf;
        end
        if (q.control[CTL_STOP_RISE] ? rise : fall) begin
          next_q.stop_cnt = ns; // see R1
          stop_ev = ns == q.edge_setup[STOP_EDGE_LSB +: 4]; // see R1 R18
        end
        case (q.sync_st)
          LBS_ARMED: begin
            if (fall && nf == q.edge_setup[START_EDGE_LSB +: 4]) begin // see R3
              next_q.sync_st = LBS_RUN;
              next_q.sync_cnt = 16'h0;
              next_q.status[ST_START] = 1'b1;
            end
          end
          LBS_RUN: begin
            if (stop_ev) begin
              // Final count is held until the next break. see R24
              // Identifier and data bytes that follow leave it alone. see R19 R20
              next_q.sync_st = LBS_DONE;
              next_q.status[ST_STOP] = 1'b1;
              next_q.irq = 1'b1;
              next_q.brk_ok = 1'b0;
            end else if (sync_tick && q.sync_cnt != 16'hffff) begin
              next_q.sync_cnt = q.sync_cnt + 16'h1; // see R7
            end
          end
          default: begin
          end
        endcase
      end
      if (q.control[CTL_EDGE_CLR]) begin
        next_q.fall_cnt = 4'h0;
        next_q.stop_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.rx_meta <= 1'b1;
      q.rx_sync <= 1'b1;
      q.rx_prev <= 1'b1;
      q.edge_setup <= EDGE_SETUP_RESET; // see R2 R4
      q.cmp <= BRK_CMP_RESET; // see R14
      q.control <= CONTROL_RESET;
      q.sync_st <= LBS_IDLE;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_brk_match_flag: assert property (ce && match_cause |=> q.status[ST_BREAK] && q.irq) // see R11
    else $error("break match did not flag");
  a_brk_overflow_err: assert property (ce && run_ok && q.brk_run && lp_tick && !fall && !rd_brk
    && q.brk_cnt == 12'hfff |=> q.status[ST_BRK_ERR] && !q.brk_run && q.irq) // see R13
    else $error("break overflow not reported");
  a_fall_clears_brk: assert property (ce && run_ok && fall |=> q.brk_cnt == 12'h0 && q.brk_run) // see R9
    else $error("falling edge did not clear break timer");
  a_read_clears_brk: assert property (ce && run_ok && rd_brk |=> q.brk_cnt == 12'h0) // see R9
    else $error("break read did not clear timer");
  a_brk_write_cmp: assert property (ce && wr_fire && !q.control[CTL_RESET]
    && q.axi.aw_addr == ADDR_BRK && q.axi.w_strb == 4'hf
    |=> q.cmp == $past(q.axi.w_data[11:0])) // see R10
    else $error("compare value not loaded");
  a_sync_needs_break: assert property (ce && q.sync_st == LBS_IDLE && !match_cause
    |=> q.sync_st == LBS_IDLE) // see R15
    else $error("sync timing began without break");
  a_sync_start_edge: assert property (ce && run_ok && !q.control[CTL_MODE]
    && !q.control[CTL_EDGE_CLR] && q.brk_ok && q.sync_st == LBS_ARMED && fall
    && !match_cause && inc4(q.fall_cnt) == q.edge_setup[3:0]
    |=> q.sync_st == LBS_RUN && q.sync_cnt == 16'h0) // see R3
    else $error("sync timer did not start on edge");
  a_sync_hold_done: assert property (ce && q.sync_st == LBS_DONE && !match_cause
    && !q.control[CTL_RESET] && !(wr_fire && q.axi.aw_addr == ADDR_SYNC_TIMER)
    |=> $stable(q.sync_cnt)) // see R24
    else $error("held sync count changed");
  a_self_clear_time: assert property (ce && q.control[CTL_RESET]
    && q.clr_cnt == 9'(SELF_CLR_CYC - 1) |=> !q.control[CTL_RESET]) // see R22
    else $error("reset bit did not self clear");
  a_reset_defaults: assert property (ce && q.control[CTL_RESET]
    |=> q.edge_setup == EDGE_SETUP_RESET && q.sync_st == LBS_IDLE && !q.brk_run) // see R22
    else $error("reset bit did not restore defaults");
  a_bresp_after_both: assert property ($rose(q.axi.b_valid) |-> $past(q.axi.aw_ok && q.axi.w_ok))
    else $error("write answered before address and data");

  c_break_found: cover property (ce && match_cause);
  c_break_error: cover property (q.status[ST_BRK_ERR]);
  c_sync_done: cover property (q.sync_st == LBS_RUN ##1 q.sync_st == LBS_DONE);
  c_break_read: cover property (rd_brk);

endmodule

// *** common/lbs_pkg.sv ***
package lbs_pkg;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int SYNC_HZ = 5_000_000;
  localparam int LP_HZ = 131_000;
  localparam int SYNC_DIV = CLK_HZ / SYNC_HZ;
  localparam int LP_DIV = CLK_HZ / LP_HZ;
  localparam int SELF_CLR_NS = 15_000;
  localparam int SELF_CLR_CYC = (SELF_CLR_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_STATUS = 32'hffff0780;
  localparam logic [31:0] ADDR_CONTROL = 32'hffff0784;
  localparam logic [31:0] ADDR_SYNC_TIMER = 32'hffff0788;
  localparam logic [31:0] ADDR_EDGE_SETUP = 32'hffff078c;
  localparam logic [31:0] ADDR_BRK = 32'hffff0790;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int STOP_EDGE_LSB = 4;
  localparam int START_EDGE_LSB = 0;
  localparam logic [7:0] EDGE_SETUP_RESET = 8'h32;
  localparam logic [11:0] BRK_CMP_RESET = 12'h047;
  localparam logic [8:0] CONTROL_RESET = 9'h000;
  localparam int CTL_RESET = 0;
  localparam int CTL_EDGE_CLR = 1;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_MODE = 6;
  localparam int CTL_STOP_RISE = 7;
  localparam int ST_BREAK = 0;
  localparam int ST_START = 1;
  localparam int ST_STOP = 2;
  localparam int ST_BRK_ERR = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    LBS_IDLE = 2'b00,
    LBS_ARMED = 2'b01,
    LBS_RUN = 2'b10,
    LBS_DONE = 2'b11
  } lbs_sync_state_type;

  typedef struct packed {
    logic aw_ok;
    logic [31:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } lbs_axi_type;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic [1:0] sync_div;
    logic [7:0] lp_div;
    logic [7:0] edge_setup;
    logic [8:0] control;
    logic [8:0] clr_cnt;
    logic [11:0] cmp;
    logic [11:0] brk_cnt;
    logic brk_run;
    logic brk_ok;
    lbs_sync_state_type sync_st;
    logic [15:0] sync_cnt;
    logic [3:0] fall_cnt;
    logic [3:0] stop_cnt;
    logic [5:0] status;
    logic irq;
    lbs_axi_type axi;
  } lbs_state_type;

endpackage

// *** testbench/lbs_lin_master.sv ***
`timescale 1ns/10ps
module lbs_lin_master (
  input wire logic mclk,
  output logic lin_rx
);

  // ----------------------------------------------------------------
  // Bus levels
  // ----------------------------------------------------------------
  // The bus idles recessive through the transceiver pull-up.
  initial begin
    lin_rx = 1'b1;
  end

  task automatic hold(input logic v, input int cyc);
    @(posedge mclk);
    lin_rx <= v;
    repeat (cyc - 1) @(posedge mclk);
  endtask

  task automatic send_byte(input logic [7:0] b, input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], bc);
    end
    hold(1'b1, bc);
  endtask

  // ----------------------------------------------------------------
  // Frame header and data
  // ----------------------------------------------------------------
  task automatic frame(input int brk_bits, input int bc, input logic [5:0] id, input int nbytes);
    logic [7:0] pid;
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    hold(1'b0, brk_bits * bc);
    hold(1'b1, bc);
    send_byte(8'h55, bc);
    send_byte(pid, bc);
    for (int i = 0; i < nbytes; i++) begin
      send_byte(8'h55 ^ 8'(i << 1), bc);
    end
  endtask

endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module testbench import lbs_pkg::*;;

  logic mclk, arst_n, ce, lin_rx;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lin_irq, irq_prev;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] v, w;
  int mismatches, checks, cyc, irq_cnt, irq_dbl, n;

  lbs_lin_break_sync i_lbs_lin_break_sync (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .lin_rx(lin_rx), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .lin_irq(lin_irq));

  lbs_lin_master i_lbs_lin_master (.mclk(mclk), .lin_rx(lin_rx));

  // ----------------------------------------------------------------
  // Clock, watchdog and interrupt pulse counting
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (lin_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (lin_irq === 1'b1 && irq_prev === 1'b1) irq_dbl <= irq_dbl + 1;
    irq_prev <= lin_irq;
    if (cyc == 90000) begin
      mismatches++;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, wd, b;
    aw = 0;
    wd = 0;
    b = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar, done;
    ar = 0;
    done = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_EDGE_SETUP, v, r); `CHK(v, 32'h00000032)
    rd(ADDR_SYNC_TIMER, v, r); `CHK(v, 32'h00000000)
    rd(ADDR_BRK, v, r); `CHK(v, 32'h00000000)
    rd(32'hffff07a0, v, r); `CHK(r, RESP_SLVERR)
    wr(32'hffff07a0, 32'h00000001, r); `CHK(r, RESP_SLVERR)
    wr(ADDR_BRK, 32'h00000004, r); `CHK(r, RESP_OKAY)
    rd(ADDR_BRK, v, r); `CHK(v, 32'h00000000)
  endtask

  // Disabled block and pulse mode both ignore a full frame.
  task automatic t_disabled;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CONTROL, k ? 32'h00000044 : 32'h00000000, r);
      n = irq_cnt;
      i_lbs_lin_master.frame(13, 100, 6'h12, 1);
      rd(ADDR_STATUS, v, r); `CHK(v[2:0], 3'b000)
      `CHK(irq_cnt - n, 0)
    end
  endtask

  // The break timer is read early in the break, before any match, which
  // restarts it; the break is long enough that the compare matches once.
  task automatic t_frame;
    wr(ADDR_CONTROL, 32'h00000004, r);
    wr(ADDR_STATUS, 32'h00000017, r);
    n = irq_cnt;
    fork
      i_lbs_lin_master.frame(13, 100, 6'h12, 2);
      begin
        repeat (300) @(posedge mclk);
        rd(ADDR_BRK, v, r);
        rd(ADDR_BRK, w, r);
      end
    join
    `CHK(v >= 1 && v <= 2, 1'b1)
    `CHK(w <= 1, 1'b1)
    rd(ADDR_STATUS, v, r); `CHK(v[2:0], 3'b111)
    `CHK(irq_cnt - n, 2)
    `CHK(irq_dbl, 0)
    rd(ADDR_SYNC_TIMER, v, r); `CHK(v >= 49 && v <= 51, 1'b1)
    repeat (100) @(posedge mclk);
    rd(ADDR_SYNC_TIMER, w, r); `CHK(w, v)
  endtask

  // Stop on the sixth fall (first to fifth sync fall), then on rise three.
  task automatic t_edges;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CONTROL, k ? 32'h00000084 : 32'h00000004, r);
      wr(ADDR_EDGE_SETUP, k ? 32'h00000032 : 32'h00000062, r);
      i_lbs_lin_master.frame(13, 100, 6'h12, 1);
      rd(ADDR_SYNC_TIMER, v, r);
      `CHK(k ? (v >= 74 && v <= 76) : (v >= 199 && v <= 201), 1'b1)
    end
  endtask

  // A low pulse shorter than the compare value is no break.
  task automatic t_short;
    wr(ADDR_CONTROL, 32'h00000004, r);
    wr(ADDR_STATUS, 32'h00000017, r);
    n = irq_cnt;
    i_lbs_lin_master.frame(3, 100, 6'h12, 1);
    rd(ADDR_STATUS, v, r); `CHK(v[2:0], 3'b000)
    `CHK(irq_cnt - n, 0)
  endtask

  task automatic t_soft;
    wr(ADDR_EDGE_SETUP, 32'h00000055, r);
    wr(ADDR_CONTROL, 32'h00000005, r);
    repeat (100) @(posedge mclk);
    rd(ADDR_CONTROL, v, r); `CHK(v[0], 1'b1)
    repeat (220) @(posedge mclk);
    rd(ADDR_CONTROL, v, r); `CHK(v, 32'h00000004)
    rd(ADDR_EDGE_SETUP, v, r); `CHK(v, 32'h00000032)
  endtask

  // After the software reset the compare is 0x47 again: a 70-tick low is
  // no break yet, and the timer keeps counting past the match.
  task automatic t_cmp_reset;
    n = irq_cnt;
    i_lbs_lin_master.hold(1'b0, 10600);
    rd(ADDR_STATUS, v, r); `CHK(v[0], 1'b0)
    i_lbs_lin_master.hold(1'b0, 400);
    rd(ADDR_BRK, v, r); `CHK(v > 32'h00000047, 1'b1)
    i_lbs_lin_master.hold(1'b1, 100);
    rd(ADDR_STATUS, v, r); `CHK(v[2:0], 3'b001)
    `CHK(irq_cnt - n, 1)
  endtask

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_disabled;
    t_frame;
    t_edges;
    t_short;
    t_soft;
    t_cmp_reset;
    finish_test;
  end

endmodule
